// *** src/tmb_ports.sv ***
// Purpose: output group C, bidirectional group D with interrupt, open-drain group E with beep.
// Assumes: instructions arrive one per cycle from the core on clk_i; backup_i is a core level.
// Notes:

module tmb_ports
  import tmb_pkg::*;
#(
  parameter logic [3:0] TONE_MAP = TONE_MAP_DEF,
  parameter int HALF_LO_CYC = TONE_LO_HALF_CYC,
  parameter int HALF_HI_CYC = TONE_HI_HALF_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // core side
  input wire tmb_instr_t instr_i,
  input wire logic backup_i,
  output logic [3:0] d_rd_o,
  output logic irq_req_o,
  // group C pins
  output logic [3:0] c_out_o,
  // group D pins
  input wire logic [3:0] d_pin_i,
  output logic [3:0] d_out_o,
  output logic [3:0] d_oe_n_o,
  // group E open-drain pins
  output logic [1:0] e_out_o,
  output logic [1:0] e_oe_n_o
);
  logic [3:0] c_latch_q;
  logic [3:0] d_latch_q;
  logic [3:0] d_dir_q;
  logic [1:0] d_func_q;
  logic [1:0] e_latch_q;
  logic beep_en_q;
  logic beep_hi_q;
  logic float_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic irq_prev_q;
  logic [3:0] d_rd_q;
  logic irq_q;
  logic [3:0] d_out_q;
  logic [3:0] d_oe_n_q;
  logic [1:0] e_oe_n_q;
  logic tone_w;

  // the core is stopped in backup, so instructions are ignored there
  wire logic run_w = ce_i && !backup_i;
  wire logic is_out_w = (instr_i.op == TMB_OP_OUT);
  wire logic is_setb_w = (instr_i.op == TMB_OP_SETB);
  wire logic is_clrb_w = (instr_i.op == TMB_OP_CLRB);
  wire logic is_wr_w = is_out_w || is_setb_w || is_clrb_w;
  wire logic wr_c_w = run_w && is_wr_w && (instr_i.grp == TMB_GRP_C);
  wire logic wr_d_w = run_w && is_wr_w && (instr_i.grp == TMB_GRP_D);
  wire logic wr_e_w = run_w && is_wr_w && (instr_i.grp == TMB_GRP_E);
  wire logic beep_w = run_w && (instr_i.op == TMB_OP_BEEP);
  wire logic setup_w = run_w && (instr_i.op == TMB_OP_SETUP);
  wire logic setup_func_w = setup_w && (instr_i.sel == SETUP_SEL_D_FUNC);
  wire logic setup_dir_w = setup_w && (instr_i.sel == SETUP_SEL_D_DIR);
  wire logic tone_hi_w = TONE_MAP[instr_i.data[1:0]];

  function automatic logic [3:0] upd(input logic [3:0] cur, input tmb_instr_t ins);
    logic [3:0] r;
    r = cur;
    if (ins.op == TMB_OP_OUT) begin
      r = ins.data;
    end else if (ins.op == TMB_OP_SETB) begin
      r = cur | ins.data;
    end else if (ins.op == TMB_OP_CLRB) begin
      r = cur & ~ins.data;
    end
    return r;
  endfunction : upd

  wire logic [3:0] c_latch_d = wr_c_w ? upd(c_latch_q, instr_i) : c_latch_q;
  wire logic [3:0] d_latch_d = wr_d_w ? upd(d_latch_q, instr_i) : d_latch_q;
  wire logic [3:0] e_upd_w = upd({2'b00, e_latch_q}, instr_i);
  wire logic [1:0] e_latch_d = wr_e_w ? e_upd_w[1:0] : e_latch_q;
  wire logic [3:0] d_dir_d = setup_dir_w ? instr_i.data : d_dir_q;
  wire logic [1:0] d_func_d = setup_func_w ? instr_i.data[1:0] : d_func_q;
  wire logic beep_en_d = beep_w ? instr_i.data[BEEP_EN_BIT] : beep_en_q;
  wire logic beep_hi_d = beep_w ? tone_hi_w : beep_hi_q;
  // backup holds the float; leaving needs a group E write (output, set or clear bit) or a beep instruction
  wire logic float_d = backup_i || (float_q && !(wr_e_w || beep_w));

  // interrupt edge on the second sync stage, only while bit 0 is an enabled input
  wire logic irq_en_w = d_func_q[FUNC_IRQ_EN_BIT] && !d_dir_q[0] && !backup_i;
  wire logic edge_w = d_func_q[FUNC_IRQ_FALL_BIT] ? (irq_prev_q && !sync2_q[0])
                                                  : (!irq_prev_q && sync2_q[0]);
  wire logic irq_d = irq_en_w && edge_w;

  wire logic [3:0] d_rd_d = backup_i ? 4'h0 : sync2_q;
  wire logic [3:0] d_oe_n_d = backup_i ? 4'hF : ~d_dir_q;
  wire logic e0_lvl_w = beep_en_q ? tone_w : e_latch_q[0];
  // bit 1 has no alternate source
  wire logic [1:0] e_oe_n_d = (backup_i || float_q) ? 2'b11
                                                    : {e_latch_q[1], e0_lvl_w};

  tmb_tone #(
    .HALF_LO_CYC(HALF_LO_CYC),
    .HALF_HI_CYC(HALF_HI_CYC)
  ) u_tone (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .en_i(beep_en_q),
    .hi_i(beep_hi_q),
    .tone_o(tone_w)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      c_latch_q <= C_LATCH_RST;
      d_latch_q <= D_LATCH_RST;
      d_dir_q <= D_DIR_RST;
      d_func_q <= D_FUNC_RST;
      e_latch_q <= E_LATCH_RST;
      beep_en_q <= 1'b0;
      beep_hi_q <= 1'b0;
      float_q <= 1'b0;
    end else if (ce_i) begin
      c_latch_q <= c_latch_d;
      d_latch_q <= d_latch_d;
      d_dir_q <= d_dir_d;
      d_func_q <= d_func_d;
      e_latch_q <= e_latch_d;
      beep_en_q <= beep_en_d;
      beep_hi_q <= beep_hi_d;
      float_q <= float_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      irq_prev_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= d_pin_i;
      sync2_q <= sync1_q;
      irq_prev_q <= sync2_q[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      d_rd_q <= 4'h0;
      irq_q <= 1'b0;
      d_out_q <= D_LATCH_RST;
      d_oe_n_q <= 4'hF;
      e_oe_n_q <= 2'b11;
    end else if (ce_i) begin
      d_rd_q <= d_rd_d;
      irq_q <= irq_d;
      d_out_q <= d_latch_q;
      d_oe_n_q <= d_oe_n_d;
      e_oe_n_q <= e_oe_n_d;
    end
  end

  assign d_rd_o = d_rd_q;
  assign irq_req_o = irq_q;
  assign c_out_o = c_latch_q;
  assign d_out_o = d_out_q;
  assign d_oe_n_o = d_oe_n_q;
  // open-drain: the data level is always low, the enable does the work
  assign e_out_o = '0;
  assign e_oe_n_o = e_oe_n_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_irq_cause;
    irq_req_o |-> $past(irq_en_w) && $past(edge_w);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled edge");

  property p_dir_write;
    setup_dir_w |=> d_dir_q == $past(instr_i.data);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not updated");

  property p_dir_pin;
    ce_i && !backup_i |=> d_oe_n_o == ~$past(d_dir_q);
  endproperty
  a_dir_pin: assert property (p_dir_pin) else $error("direction not on pin enable");

  property p_backup_d;
    ce_i && backup_i |=> d_oe_n_o == 4'hF && d_rd_o == 4'h0;
  endproperty
  a_backup_d: assert property (p_backup_d) else $error("group D active in backup");

  property p_reset_state;
    !$past(rst_n_i) |-> d_oe_n_o == 4'hF && d_dir_q == 4'h0 && !beep_en_q;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_e0_latch;
    ce_i && !backup_i && !float_q && !beep_en_q |=> e_oe_n_o[0] == $past(e_latch_q[0]);
  endproperty
  a_e0_latch: assert property (p_e0_latch) else $error("bit 0 not from latch");

  property p_e0_tone;
    ce_i && !backup_i && !float_q && beep_en_q |=> e_oe_n_o[0] == $past(tone_w);
  endproperty
  a_e0_tone: assert property (p_e0_tone) else $error("bit 0 not carrying tone");

  property p_tone_sel;
    beep_w |=> beep_hi_q == TONE_MAP[$past(instr_i.data[1:0])];
  endproperty
  a_tone_sel: assert property (p_tone_sel) else $error("tone select wrong");

  property p_latch_only;
    wr_e_w && is_out_w && beep_en_q |=> beep_en_q && e_latch_q[0] == $past(instr_i.data[0]);
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("output instr disturbed tone");

  property p_e1_plain;
    ce_i && !backup_i && !float_q |=> e_oe_n_o[1] == $past(e_latch_q[1]);
  endproperty
  a_e1_plain: assert property (p_e1_plain) else $error("bit 1 not from latch");

  property p_float_hold;
    ce_i && float_q && !wr_e_w && !beep_w |=> float_q ##0 e_oe_n_o == 2'b11;
  endproperty
  a_float_hold: assert property (p_float_hold) else $error("float ended early");

  property p_od_low;
    e_out_o == 2'b00;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain drives high");

  property p_setb;
    wr_c_w && is_setb_w |=> c_out_o == ($past(c_out_o) | $past(instr_i.data));
  endproperty
  a_setb: assert property (p_setb) else $error("set bit failed");

  property p_clrb;
    wr_c_w && is_clrb_w |=> c_out_o == ($past(c_out_o) & ~$past(instr_i.data));
  endproperty
  a_clrb: assert property (p_clrb) else $error("clear bit failed");

  property p_out_write;
    wr_c_w && is_out_w |=> c_out_o == $past(instr_i.data);
  endproperty
  a_out_write: assert property (p_out_write) else $error("output write failed");

  property p_func_write;
    setup_func_w |=> d_func_q == $past(instr_i.data[1:0]);
  endproperty
  a_func_write: assert property (p_func_write) else $error("function not updated");

  property p_d_out;
    ce_i |=> d_out_o == $past(d_latch_q);
  endproperty
  a_d_out: assert property (p_d_out) else $error("group D data not from latch");

  property p_rd_path;
    ce_i && !backup_i |=> d_rd_o == $past(sync2_q);
  endproperty
  a_rd_path: assert property (p_rd_path) else $error("group D read path wrong");

  property p_backup_irq;
    ce_i && backup_i |=> !irq_req_o;
  endproperty
  a_backup_irq: assert property (p_backup_irq) else $error("irq raised in backup");

  property p_float_set;
    ce_i && backup_i |=> float_q && e_oe_n_o == 2'b11;
  endproperty
  a_float_set: assert property (p_float_set) else $error("open-drain not floated");

  property p_float_end;
    ce_i && float_q && (wr_e_w || beep_w) |=> !float_q;
  endproperty
  a_float_end: assert property (p_float_end) else $error("float not ended");

  property p_tone_idle;
    ce_i && !beep_en_q |=> tone_w;
  endproperty
  a_tone_idle: assert property (p_tone_idle) else $error("tone not idle");

  c_tone_on: cover property (beep_w && instr_i.data[BEEP_EN_BIT] ##1 beep_en_q);
  c_irq: cover property (irq_req_o);
  c_float_end: cover property (float_q && !backup_i ##1 !float_q);
  c_backup: cover property (ce_i && backup_i ##1 float_q);
  c_tone_hi: cover property (beep_en_q && beep_hi_q);
endmodule : tmb_ports

// *** src/tmb_tone.sv ***
// Purpose: shared constants and types, plus the beep tone divider.
// Assumes: clk_i at 100 MHz; synchronous active-low reset that overrides ce_i.
// Notes: the tone idles released (high), so a beep starts released; while off and not in backup or float, open-drain bit 0 follows its latch.

package tmb_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TONE_LO_HZ = 1500;
  localparam int TONE_HI_HZ = 3100;
  // half periods round down, the tone runs marginally fast
  localparam int TONE_LO_HALF_CYC = CLK_HZ / (2 * TONE_LO_HZ);
  localparam int TONE_HI_HALF_CYC = CLK_HZ / (2 * TONE_HI_HZ);
  localparam int TONE_CNT_W = 16;

  localparam logic [3:0] SETUP_SEL_D_FUNC = 4'h4;
  localparam logic [3:0] SETUP_SEL_D_DIR = 4'h5;
  localparam int FUNC_IRQ_EN_BIT = 0;
  localparam int FUNC_IRQ_FALL_BIT = 1;
  localparam int BEEP_EN_BIT = 2;

  localparam logic [3:0] C_LATCH_RST = 4'h0;
  localparam logic [3:0] D_LATCH_RST = 4'h0;
  localparam logic [3:0] D_DIR_RST = 4'h0;
  localparam logic [1:0] E_LATCH_RST = 2'h3;
  localparam logic [1:0] D_FUNC_RST = 2'h0;
  // beep code b1:b0 -> 1 selects the high tone
  localparam logic [3:0] TONE_MAP_DEF = 4'hA;

  typedef enum logic [2:0] {
    TMB_OP_NONE = 3'b000,
    TMB_OP_OUT = 3'b001,
    TMB_OP_SETB = 3'b010,
    TMB_OP_CLRB = 3'b011,
    TMB_OP_SETUP = 3'b100,
    TMB_OP_BEEP = 3'b101
  } tmb_op_t;

  typedef enum logic [1:0] {
    TMB_GRP_C = 2'b00,
    TMB_GRP_D = 2'b01,
    TMB_GRP_E = 2'b10
  } tmb_grp_t;

  typedef struct packed {
    tmb_op_t op;
    tmb_grp_t grp;
    logic [3:0] sel;
    logic [3:0] data;
  } tmb_instr_t;
endpackage : tmb_pkg

module tmb_tone
  import tmb_pkg::*;
#(
  parameter int HALF_LO_CYC = TONE_LO_HALF_CYC,
  parameter int HALF_HI_CYC = TONE_HI_HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // control
  input wire logic en_i,
  input wire logic hi_i,
  // tone
  output logic tone_o
);
  localparam logic [TONE_CNT_W-1:0] LO_LAST = TONE_CNT_W'(HALF_LO_CYC - 1);
  localparam logic [TONE_CNT_W-1:0] HI_LAST = TONE_CNT_W'(HALF_HI_CYC - 1);

  logic [TONE_CNT_W-1:0] cnt_q;
  logic [TONE_CNT_W-1:0] cnt_d;
  logic tone_q;
  logic tone_d;
  wire logic [TONE_CNT_W-1:0] last_w = hi_i ? HI_LAST : LO_LAST;
  wire logic wrap_w = (cnt_q >= last_w);

  assign cnt_d = (!en_i || wrap_w) ? '0 : cnt_q + TONE_CNT_W'(1);
  assign tone_d = !en_i ? 1'b1 : (wrap_w ? ~tone_q : tone_q);
  assign tone_o = tone_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      tone_q <= 1'b1;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      tone_q <= tone_d;
    end
  end
endmodule : tmb_tone

// *** testbench/tmb_board.sv ***
// Purpose: board model facing the port block: pull-ups, key and interrupt sources.
// Assumes: open-drain lines carry pull-ups; released group D lines follow ext_d_i.
// Notes: behavioural and zero-delay, so pin timing is not modelled.
module tmb_board (
  // device side
  input wire logic [3:0] d_out_i,
  input wire logic [3:0] d_oe_n_i,
  input wire logic [1:0] e_out_i,
  input wire logic [1:0] e_oe_n_i,
  // board side
  input wire logic [3:0] ext_d_i,
  output logic [3:0] d_pin_o,
  output logic [1:0] e_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven line shows the device value, a released one the board source
  assign d_pin_o = (d_out_i & ~d_oe_n_i) | (ext_d_i & d_oe_n_i);
  // the pull-up wins unless the device sinks the line
  assign e_wire_o = e_oe_n_i | e_out_i;
endmodule : tmb_board

// *** testbench/tmb_ports_tb.sv ***
// Purpose: self-checking bench for the general-purpose port block.
// Assumes: inputs change on the falling edge; tone half periods shortened to 5 and 3.
// Notes: tone rates are measured as cycles between flips of open-drain bit 0.
module tmb_ports_tb import tmb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic backup_i = 1'b0;
  tmb_instr_t instr_i = '0;
  logic [3:0] ext_d = 4'h0;
  logic [3:0] d_pin, d_rd, d_out, d_oe_n, c_out;
  logic [1:0] e_out, e_oe_n, e_wire;
  logic irq;
  int fail_count = 0;
  int checks = 0;

  always #5 clk_i = ~clk_i;

  tmb_ports #(.HALF_LO_CYC(5), .HALF_HI_CYC(3)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .instr_i(instr_i),
    .backup_i(backup_i), .d_rd_o(d_rd), .irq_req_o(irq), .c_out_o(c_out),
    .d_pin_i(d_pin), .d_out_o(d_out), .d_oe_n_o(d_oe_n), .e_out_o(e_out),
    .e_oe_n_o(e_oe_n));

  tmb_board i_board (
    .d_out_i(d_out), .d_oe_n_i(d_oe_n), .e_out_i(e_out), .e_oe_n_i(e_oe_n),
    .ext_d_i(ext_d), .d_pin_o(d_pin), .e_wire_o(e_wire));

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic issue(input tmb_op_t o, input tmb_grp_t g, input logic [3:0] s,
                       input logic [3:0] d);
    @(negedge clk_i);
    instr_i = '{o, g, s, d};
    @(negedge clk_i);
    instr_i = '0;
    repeat (2) @(negedge clk_i);
  endtask : issue

  // cycles until the next flip of open-drain bit 0; a stuck line ends the run
  task automatic wait_flip(output int n);
    logic last;
    n = 0;
    last = e_wire[0];
    while (e_wire[0] === last) begin
      @(negedge clk_i);
      n++;
      if (n > 40) begin
        fail_count++;
        conclude();
      end
    end
  endtask : wait_flip

  // the first flips may be partial periods left from an earlier rate
  task automatic tone_half(output int n);
    repeat (3) wait_flip(n);
  endtask : tone_half

  task automatic irq_edge(input logic lvl, input int exp);
    int n;
    n = 0;
    ext_d[0] = lvl;
    repeat (6) begin
      @(negedge clk_i);
      if (irq === 1'b1) n++;
    end
    chk("irq_req", 8'(n), 8'(exp));
  endtask : irq_edge

  // reset is driven here so that a mid-run reset repeats the same checks
  task automatic t_reset();
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk("c_out", {4'h0, c_out}, 8'h00);
    chk("d_oe_n", {4'h0, d_oe_n}, 8'h0F);
    chk("e_wire", {6'h0, e_wire}, 8'h03);
    chk("irq", {7'h0, irq}, 8'h00);
  endtask : t_reset

  task automatic t_port_c();
    issue(TMB_OP_OUT, TMB_GRP_C, 4'h0, 4'hA);
    chk("c_out", {4'h0, c_out}, 8'h0A);
    issue(TMB_OP_SETB, TMB_GRP_C, 4'h0, 4'h5);
    chk("c_out", {4'h0, c_out}, 8'h0F);
    issue(TMB_OP_CLRB, TMB_GRP_C, 4'h0, 4'h3);
    chk("c_out", {4'h0, c_out}, 8'h0C);
  endtask : t_port_c

  task automatic t_port_d();
    issue(TMB_OP_SETUP, TMB_GRP_D, SETUP_SEL_D_DIR, 4'hA);
    issue(TMB_OP_OUT, TMB_GRP_D, 4'h0, 4'hF);
    chk("d_oe_n", {4'h0, d_oe_n}, 8'h05);
    chk("d_out", {4'h0, d_out}, 8'h0F);
    chk("d_pin", {4'h0, d_pin}, 8'h0A);
    repeat (3) @(negedge clk_i);
    chk("d_rd", {4'h0, d_rd}, 8'h0A);
    issue(TMB_OP_SETUP, TMB_GRP_D, SETUP_SEL_D_DIR, 4'h0);
  endtask : t_port_d

  task automatic t_irq();
    issue(TMB_OP_SETUP, TMB_GRP_D, SETUP_SEL_D_FUNC, 4'h1);
    irq_edge(1'b1, 1);
    irq_edge(1'b0, 0);
    issue(TMB_OP_SETUP, TMB_GRP_D, SETUP_SEL_D_FUNC, 4'h3);
    irq_edge(1'b1, 0);
    irq_edge(1'b0, 1);
  endtask : t_irq

  task automatic t_tone();
    int n;
    for (int c = 0; c < 4; c++) begin
      issue(TMB_OP_BEEP, TMB_GRP_E, 4'h0, {2'b01, 2'(c)});
      tone_half(n);
      chk("tone_half", 8'(n), (c % 2 == 1) ? 8'h03 : 8'h05);
    end
    // latch writes while toning must leave the tone alone
    issue(TMB_OP_OUT, TMB_GRP_E, 4'h0, 4'h0);
    tone_half(n);
    chk("tone_half", 8'(n), 8'h03);
    chk("e_wire1", {7'h0, e_wire[1]}, 8'h00);
    issue(TMB_OP_BEEP, TMB_GRP_E, 4'h0, 4'h1);
    repeat (8) @(negedge clk_i);
    chk("e_wire", {6'h0, e_wire}, 8'h00);
  endtask : t_tone

  // pins high and two outputs driven, so every backup check can trip
  task automatic t_backup();
    int n;
    ext_d = 4'hF;
    issue(TMB_OP_SETUP, TMB_GRP_D, SETUP_SEL_D_DIR, 4'h3);
    chk("d_rd", {4'h0, d_rd}, 8'h0F);
    backup_i = 1'b1;
    // instructions are ignored while the core sleeps
    issue(TMB_OP_OUT, TMB_GRP_C, 4'h0, 4'h0);
    chk("c_out", {4'h0, c_out}, 8'h0C);
    chk("e_wire", {6'h0, e_wire}, 8'h03);
    chk("d_oe_n", {4'h0, d_oe_n}, 8'h0F);
    chk("d_rd", {4'h0, d_rd}, 8'h00);
    backup_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("d_oe_n", {4'h0, d_oe_n}, 8'h0C);
    chk("d_rd", {4'h0, d_rd}, 8'h0F);
    chk("e_wire", {6'h0, e_wire}, 8'h03);
    issue(TMB_OP_SETB, TMB_GRP_E, 4'h0, 4'h0);
    chk("e_wire", {6'h0, e_wire}, 8'h00);
    backup_i = 1'b1;
    repeat (2) @(negedge clk_i);
    backup_i = 1'b0;
    issue(TMB_OP_BEEP, TMB_GRP_E, 4'h0, 4'h4);
    chk("e_wire1", {7'h0, e_wire[1]}, 8'h00);
    tone_half(n);
    chk("tone_half", 8'(n), 8'h05);
  endtask : t_backup

  initial begin
    t_reset();
    t_port_c();
    t_port_d();
    t_irq();
    t_tone();
    t_backup();
    t_reset();
    conclude();
  end
endmodule : tmb_ports_tb
